/* design/adc_conversion_sequencer.sv */
// Functional notes
// - result from last four samples, mux resets
// - four delta-sigma operating modes
// - start by control bit or request
// - ready flag holds until result read
// - single: four conversions, three prime decimator
// - single returns to standby after read
// - completion status readable for polling
// - continuous primes once, then every sample
// - host avoids mux switching in continuous
// - multi re-primes and restarts automatically
// - turbo: multi up to 16 bits
// - request source may be left idle
// - twelve-bit binary search, msb first
// - sar starts by bit or trigger
// - ten microsecond wait after wake
// - done flag holds until result read
// - done flag usable as request source
// - single select: one per trigger
// - continuous results drainable by dma
// - sar clock at most 14 MHz
//
// Our own choices: the address map and the address-and-strobe port.
`include "adc_seq_defines.svh"
`timescale 1ns/1ns
module adc_conversion_sequencer
(
    input  wire logic                       clk,
    input  wire logic                       sys_rst,
    adc_seq_if.dev                          link,
    input  wire logic                       mod_sample_strobe,
    input  wire adc_seq_pkg::ds_word_type   mod_sample,
    input  wire logic                       sar_comp_high,
    output logic                            ds_dec_reset,
    output adc_seq_pkg::sar_word_type       sar_dac_code
);
    import adc_seq_pkg::*;

    ds_state_type  ds_state_q;
    ds_word_type   win_q [0:`DS_WINDOW-1];
    logic [2:0]    fill_q;
    logic          ds_ready_q;
    ds_word_type   ds_result_q;
    logic          ds_start;
    logic          ds_take;
    logic          ds_full;
    logic          ds_reprime;
    logic          ds_clear;
    logic [21:0]   ds_sum;

    sar_state_type sar_state_q;
    logic [7:0]    wait_q;
    logic [1:0]    div_q;
    logic          sar_tick;
    sar_word_type  sar_mask_q;
    sar_word_type  sar_code_q;
    sar_word_type  sar_result_q;
    logic          sar_done_q;
    logic          sar_start;
    logic          sar_finish;
    sar_word_type  sar_keep;

    assign ds_start   = link.ds_start_bit | link.ds_convert_request;
    assign ds_take    = (ds_state_q == DS_RUN) && mod_sample_strobe;
    assign ds_full    = ds_take && (fill_q >= 3'h3);
    assign ds_reprime = (link.ds_mode == DS_MULTI)
                     || ((link.ds_mode == DS_TURBO) && (link.ds_res <= `TURBO_SPLIT_BITS));
    assign ds_clear   = ((ds_state_q == DS_STANDBY) && ds_start) || link.ds_mux_switch
                     || (ds_full && ds_reprime);
    assign ds_sum     = {2'h0, win_q[1]} + {2'h0, win_q[2]} + {2'h0, win_q[3]}
                     + {2'h0, mod_sample};

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ds_state_q <= DS_STANDBY;
        end
        else if (link.ds_stop)
        begin
            ds_state_q <= DS_STANDBY;
        end
        else
        begin
            case (ds_state_q)
                DS_STANDBY:
                begin
                    if (ds_start)
                    begin
                        ds_state_q <= DS_RUN;
                    end
                end
                DS_RUN:
                begin
                    if (ds_full && (link.ds_mode == DS_SINGLE))
                    begin
                        ds_state_q <= DS_HOLD;
                    end
                end
                DS_HOLD:
                begin
                    if (link.ds_read)
                    begin
                        ds_state_q <= DS_STANDBY;
                    end
                end
                default:
                begin
                    ds_state_q <= DS_STANDBY;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            fill_q <= 3'h0;
            for (int i = 0; i < `DS_WINDOW; i++)
            begin
                win_q[i] <= 20'h00000;
            end
        end
        else
        begin
            if (ds_take)
            begin
                win_q[0] <= win_q[1];
                win_q[1] <= win_q[2];
                win_q[2] <= win_q[3];
                win_q[3] <= mod_sample;
            end
            if (ds_clear)
            begin
                fill_q <= 3'h0;
            end
            else if (ds_take && (fill_q != 3'h4))
            begin
                fill_q <= fill_q + 3'h1;
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ds_result_q  <= 20'h00000;
            ds_ready_q   <= 1'b0;
            ds_dec_reset <= 1'b0;
        end
        else
        begin
            ds_dec_reset <= ds_clear;
            if (ds_full)
            begin
                ds_result_q <= ds_sum[21:2];
            end
            if (ds_full)
            begin
                ds_ready_q <= 1'b1;
            end
            else if (link.ds_read)
            begin
                ds_ready_q <= 1'b0;
            end
        end
    end

    assign link.ds_result_ready = ds_ready_q;
    assign link.ds_result       = ds_result_q;
    assign link.ds_busy         = (ds_state_q != DS_STANDBY);

    // bit clock well under the limit
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            div_q <= 2'h0;
        end
        else
        begin
            div_q <= (div_q == 2'(`SAR_DIV_CYC - 1)) ? 2'h0 : div_q + 2'h1;
        end
    end
    assign sar_tick = (div_q == 2'(`SAR_DIV_CYC - 1));

    assign sar_start  = link.sar_start_bit | link.sar_trigger | ~link.sar_single_trigger_sel;
    assign sar_finish = (sar_state_q == SAR_CONV) && sar_tick && sar_mask_q[0];
    // keep bit when input above dac
    assign sar_keep   = sar_comp_high ? sar_code_q : (sar_code_q & ~sar_mask_q);

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sar_state_q <= SAR_WAKE;
            wait_q      <= 8'h00;
            sar_mask_q  <= 12'h000;
            sar_code_q  <= 12'h000;
        end
        else if (link.sar_wake)
        begin
            sar_state_q <= SAR_WAKE;
            wait_q      <= 8'h00;
        end
        else
        begin
            case (sar_state_q)
                SAR_WAKE:
                begin
                    if (wait_q == 8'(`SAR_WAIT_CYC - 1))
                    begin
                        sar_state_q <= SAR_IDLE;
                    end
                    else
                    begin
                        wait_q <= wait_q + 8'h01;
                    end
                end
                SAR_IDLE:
                begin
                    if (sar_start)
                    begin
                        sar_state_q <= SAR_CONV;
                        sar_mask_q  <= 12'h800;
                        sar_code_q  <= 12'h800;
                    end
                end
                SAR_CONV:
                begin
                    if (sar_tick)
                    begin
                        sar_code_q <= sar_keep | (sar_mask_q >> 1);
                        sar_mask_q <= sar_mask_q >> 1;
                        if (sar_mask_q[0])
                        begin
                            sar_state_q <= SAR_IDLE;
                        end
                    end
                end
                default:
                begin
                    sar_state_q <= SAR_WAKE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sar_result_q <= 12'h000;
            sar_done_q   <= 1'b0;
        end
        else
        begin
            if (sar_finish)
            begin
                sar_result_q <= sar_keep;
            end
            if (sar_finish)
            begin
                sar_done_q <= 1'b1;
            end
            else if (link.sar_read)
            begin
                sar_done_q <= 1'b0;
            end
        end
    end

    assign sar_dac_code       = sar_code_q;
    assign link.sar_done_flag = sar_done_q;
    assign link.sar_result    = sar_result_q;
    assign link.sar_busy      = (sar_state_q == SAR_CONV);
    assign link.sar_ready     = (sar_state_q != SAR_WAKE);

endmodule : adc_conversion_sequencer

/* design/adc_seq_controller.sv */
`include "adc_seq_defines.svh"
`timescale 1ns/1ns
module adc_seq_controller
(
    input  wire logic         clk,
    input  wire logic         sys_rst,
    adc_seq_if.host           link,
    input  wire logic [4:0]   addr,
    input  wire logic [31:0]  wr_data,
    input  wire logic         wr_en,
    input  wire logic         rd_en,
    output logic [31:0]       rd_data,
    input  wire logic         ext_ds_start,
    input  wire logic         ext_sar_start,
    output logic              dma_ds_req,
    output logic              dma_sar_req
);
    import adc_seq_pkg::*;

    logic [1:0]  mode_q;
    logic [4:0]  res_q;
    logic        single_q;
    logic [3:0]  mux_q;
    logic [3:0]  cmd_q;
    logic        mux_sw_q;
    logic        ds_rd_q;
    logic        sar_rd_q;
    logic        ds_req_q;
    logic        sar_req_q;
    logic        wr_ctrl;
    logic        wr_cmd;

    assign wr_ctrl = wr_en && (addr == `REG_CTRL);
    assign wr_cmd  = wr_en && (addr == `REG_CMD);

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            mode_q   <= 2'h0;
            res_q    <= `DS_RES_RESET;
            single_q <= 1'b1;
            mux_q    <= 4'h0;
            mux_sw_q <= 1'b0;
        end
        else
        begin
            mux_sw_q <= wr_ctrl && (wr_data[`CTRL_MUX_LSB +: 4] != mux_q);
            if (wr_ctrl)
            begin
                mode_q   <= wr_data[`CTRL_MODE_LSB +: 2];
                res_q    <= wr_data[`CTRL_RES_LSB +: 5];
                single_q <= wr_data[`CTRL_SINGLE_BIT];
                mux_q    <= wr_data[`CTRL_MUX_LSB +: 4];
            end
        end
    end

    // command pulses and result reads, one cycle each
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cmd_q     <= 4'h0;
            ds_rd_q   <= 1'b0;
            sar_rd_q  <= 1'b0;
            ds_req_q  <= 1'b0;
            sar_req_q <= 1'b0;
        end
        else
        begin
            cmd_q     <= wr_cmd ? wr_data[3:0] : 4'h0;
            ds_rd_q   <= rd_en && (addr == `REG_DS_RESULT);
            sar_rd_q  <= rd_en && (addr == `REG_SAR_RESULT);
            // trigger sources pass through one flop
            ds_req_q  <= ext_ds_start;
            sar_req_q <= ext_sar_start;
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rd_data <= 32'h00000000;
        end
        else if (rd_en)
        begin
            case (addr)
                `REG_CTRL:       rd_data <= {20'h00000, mux_q, single_q, res_q, mode_q};
                `REG_STATUS:     rd_data <= {27'h0000000, link.sar_ready, link.sar_busy,
                                             link.sar_done_flag, link.ds_busy,
                                             link.ds_result_ready};
                `REG_DS_RESULT:  rd_data <= {12'h000, link.ds_result};
                `REG_SAR_RESULT: rd_data <= {20'h00000, link.sar_result};
                default:         rd_data <= 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            dma_ds_req  <= 1'b0;
            dma_sar_req <= 1'b0;
        end
        else
        begin
            dma_ds_req  <= link.ds_result_ready & ~ds_rd_q;
            dma_sar_req <= link.sar_done_flag & ~sar_rd_q;
        end
    end

    assign link.ds_mode                = ds_mode_type'(mode_q);
    assign link.ds_res                 = res_q;
    assign link.sar_single_trigger_sel = single_q;
    // mux changes flagged, software keeps them out of continuous
    assign link.ds_mux_switch          = mux_sw_q;
    assign link.ds_start_bit           = cmd_q[`CMD_DS_START];
    assign link.ds_stop                = cmd_q[`CMD_DS_STOP];
    assign link.sar_start_bit          = cmd_q[`CMD_SAR_START];
    assign link.sar_wake               = cmd_q[`CMD_SAR_WAKE];
    assign link.ds_convert_request     = ds_req_q;
    assign link.sar_trigger            = sar_req_q;
    assign link.ds_read                = ds_rd_q;
    assign link.sar_read               = sar_rd_q;

endmodule : adc_seq_controller

/* design/adc_seq_defines.svh */
`ifndef ADC_SEQ_DEFINES_SVH
`define ADC_SEQ_DEFINES_SVH

// clock and timing
`define CLK_PERIOD_NS    100
`define SAR_WAIT_NS      10000
`define SAR_WAIT_CYC     ((`SAR_WAIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SAR_DIV_CYC      2
`define DS_WINDOW        4
`define TURBO_SPLIT_BITS 5'h10
`define DS_RES_RESET     5'h10

// register byte addresses on the host port
`define REG_CTRL         5'h00
`define REG_CMD          5'h04
`define REG_STATUS       5'h08
`define REG_DS_RESULT    5'h0C
`define REG_SAR_RESULT   5'h10

// control register fields
`define CTRL_MODE_LSB    0
`define CTRL_RES_LSB     2
`define CTRL_SINGLE_BIT  7
`define CTRL_MUX_LSB     8

// command register bits, write one to fire
`define CMD_DS_START     0
`define CMD_DS_STOP      1
`define CMD_SAR_START    2
`define CMD_SAR_WAKE     3

// status register bits
`define ST_DS_READY      0
`define ST_DS_BUSY       1
`define ST_SAR_DONE      2
`define ST_SAR_BUSY      3
`define ST_SAR_READY     4

`endif

/* design/adc_seq_if.sv */
`timescale 1ns/1ns
interface adc_seq_if;
    import adc_seq_pkg::*;

    logic                ds_convert_request;
    logic                ds_start_bit;
    logic                ds_stop;
    ds_mode_type         ds_mode;
    logic [4:0]          ds_res;
    logic                ds_mux_switch;
    logic                ds_read;
    logic                ds_result_ready;
    logic                ds_busy;
    ds_word_type         ds_result;
    logic                sar_trigger;
    logic                sar_start_bit;
    logic                sar_single_trigger_sel;
    logic                sar_wake;
    logic                sar_read;
    logic                sar_done_flag;
    logic                sar_busy;
    logic                sar_ready;
    sar_word_type        sar_result;

    modport dev
    (
        input  ds_convert_request, ds_start_bit, ds_stop, ds_mode, ds_res,
        input  ds_mux_switch, ds_read,
        output ds_result_ready, ds_busy, ds_result,
        input  sar_trigger, sar_start_bit, sar_single_trigger_sel, sar_wake, sar_read,
        output sar_done_flag, sar_busy, sar_ready, sar_result
    );

    modport host
    (
        output ds_convert_request, ds_start_bit, ds_stop, ds_mode, ds_res,
        output ds_mux_switch, ds_read,
        input  ds_result_ready, ds_busy, ds_result,
        output sar_trigger, sar_start_bit, sar_single_trigger_sel, sar_wake, sar_read,
        input  sar_done_flag, sar_busy, sar_ready, sar_result
    );
endinterface : adc_seq_if

/* design/adc_seq_pkg.sv */
package adc_seq_pkg;

    typedef enum logic [1:0]
    {
        DS_SINGLE = 2'h0,
        DS_MULTI  = 2'h1,
        DS_CONT   = 2'h2,
        DS_TURBO  = 2'h3
    } ds_mode_type;

    typedef enum logic [2:0]
    {
        DS_STANDBY = 3'h1,
        DS_RUN     = 3'h2,
        DS_HOLD    = 3'h4
    } ds_state_type;

    typedef enum logic [2:0]
    {
        SAR_WAKE = 3'h1,
        SAR_IDLE = 3'h2,
        SAR_CONV = 3'h4
    } sar_state_type;

    typedef logic [19:0] ds_word_type;
    typedef logic [11:0] sar_word_type;

endpackage : adc_seq_pkg

/* testbench/adc_conversion_sequencer_tb_top.sv */
`include "adc_seq_defines.svh"
`timescale 1ns/1ns
module adc_conversion_sequencer_tb_top;
    import adc_seq_pkg::*;
    logic         clk;
    logic         sys_rst;
    logic [4:0]   addr;
    logic [31:0]  wr_data;
    logic         wr_en;
    logic         rd_en;
    logic [31:0]  rd_data;
    logic         ext_ds_start;
    logic         ext_sar_start;
    logic         dma_ds_req;
    logic         dma_sar_req;
    logic         mod_sample_strobe;
    ds_word_type  mod_sample;
    logic         sar_comp_high;
    logic         dec_reset;
    sar_word_type sar_dac_code;
    sar_word_type ana;
    ds_word_type  hist[$];
    logic [31:0]  rdv;
    logic [31:0]  expv;
    int           n_mismatch;
    int           compares;
    int           n_dec;
    int           seed;
    int           i;

    adc_seq_if adc_seq_if_inst ();
    adc_conversion_sequencer adc_conversion_sequencer_inst (.clk(clk), .sys_rst(sys_rst),
        .link(adc_seq_if_inst), .mod_sample_strobe(mod_sample_strobe), .mod_sample(mod_sample),
        .sar_comp_high(sar_comp_high), .ds_dec_reset(dec_reset), .sar_dac_code(sar_dac_code));
    adc_seq_controller adc_seq_controller_inst (.clk(clk), .sys_rst(sys_rst),
        .link(adc_seq_if_inst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
        .rd_data(rd_data), .ext_ds_start(ext_ds_start), .ext_sar_start(ext_sar_start),
        .dma_ds_req(dma_ds_req), .dma_sar_req(dma_sar_req));
    adc_seq_checker adc_seq_checker_inst (.clk(clk), .sys_rst(sys_rst),
        .ds_convert_request(adc_seq_if_inst.ds_convert_request),
        .ds_start_bit(adc_seq_if_inst.ds_start_bit), .ds_stop(adc_seq_if_inst.ds_stop),
        .ds_read(adc_seq_if_inst.ds_read), .ds_result_ready(adc_seq_if_inst.ds_result_ready),
        .ds_busy(adc_seq_if_inst.ds_busy), .sar_trigger(adc_seq_if_inst.sar_trigger),
        .sar_start_bit(adc_seq_if_inst.sar_start_bit), .sar_wake(adc_seq_if_inst.sar_wake),
        .sar_read(adc_seq_if_inst.sar_read), .sar_done_flag(adc_seq_if_inst.sar_done_flag),
        .sar_busy(adc_seq_if_inst.sar_busy), .sar_ready(adc_seq_if_inst.sar_ready));

    // ideal comparator: the binary search should land exactly on ana
    assign sar_comp_high = (ana >= sar_dac_code);

    // decimator clears, read before the edge updates them
    always @(posedge clk)
    begin
        if (dec_reset === 1'b1)
            n_dec <= n_dec + 1;
    end

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic close_out();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : close_out

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        addr    <= a;
        wr_data <= d;
        wr_en   <= 1'b1;
        @(posedge clk);
        wr_en   <= 1'b0;
    endtask : wr

    // read data appear in the cycle after the strobe and hold until the next read
    task automatic rd(input logic [4:0] a);
        @(posedge clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        rdv = rd_data;
    endtask : rd

    // always read once: rdv may hold a stale result word
    task automatic poll(input int b);
        int k;
        rd(`REG_STATUS);
        for (k = 0; k < 300 && rdv[b] !== 1'b1; k++)
            rd(`REG_STATUS);
        if (rdv[b] !== 1'b1)
        begin
            n_mismatch++;
            $display("mismatch at %0t: status wait ran out", $time);
            close_out();
        end
    endtask : poll

    task automatic samp();
        ds_word_type v;
        v = ds_word_type'($random(seed));
        hist.push_back(v);
        @(posedge clk);
        mod_sample        <= v;
        mod_sample_strobe <= 1'b1;
        @(posedge clk);
        mod_sample_strobe <= 1'b0;
    endtask : samp

    task automatic pulse(input logic sar);
        @(posedge clk);
        ext_ds_start  <= !sar;
        ext_sar_start <= sar;
        @(posedge clk);
        ext_ds_start  <= 1'b0;
        ext_sar_start <= 1'b0;
    endtask : pulse

    function automatic logic [31:0] avg4();
        logic [21:0] s;
        s = 22'h000000;
        for (int k = 1; k <= 4; k++)
            s = s + 22'(hist[hist.size() - k]);
        return {12'h000, s[21:2]};
    endfunction : avg4

    task automatic run_ds(input ds_mode_type m, input logic [4:0] r, input logic reprime,
                          input logic mux);
        wr(`REG_CTRL, {24'h000000, 1'b1, r, m});
        wr(`REG_CMD, 32'h00000001);
        repeat (3) @(posedge clk);
        repeat (4) samp();
        poll(`ST_DS_READY);
        check({31'h0, dma_ds_req}, 32'h1);
        rd(`REG_DS_RESULT);
        check(rdv, avg4());
        if (mux)
            wr(`REG_CTRL, {20'h00000, 4'h1, 1'b1, r, m});
        samp();
        repeat (3) @(posedge clk);
        rd(`REG_STATUS);
        check({31'h0, rdv[`ST_DS_READY]}, {31'h0, !reprime});
        if (reprime)
        begin
            repeat (3) samp();
            poll(`ST_DS_READY);
        end
        rd(`REG_DS_RESULT);
        check(rdv, avg4());
        wr(`REG_CMD, 32'h00000002);
        repeat (3) @(posedge clk);
    endtask : run_ds

    initial
    begin
        seed = 67;
        n_dec = 0;
        n_mismatch = 0;
        compares = 0;
        sys_rst = 1'b1;
        addr = 5'h00;
        wr_data = 32'h00000000;
        wr_en = 1'b0;
        rd_en = 1'b0;
        ext_ds_start = 1'b0;
        ext_sar_start = 1'b0;
        mod_sample_strobe = 1'b0;
        mod_sample = 20'h00000;
        ana = 12'h000;
        rdv = 32'h00000000;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        rd(`REG_STATUS);
        check({31'h0, rdv[`ST_SAR_READY]}, 32'h0);
        rd(`REG_CTRL);
        check(rdv, 32'h000000C0);
        rd(5'h14);
        check(rdv, 32'h00000000);
        // single sample: a stray sample before start and a second start mid-run
        samp();
        pulse(1'b0);
        repeat (3) @(posedge clk);
        repeat (3) samp();
        wr(`REG_CMD, 32'h00000001);
        rd(`REG_STATUS);
        check({31'h0, rdv[`ST_DS_READY]}, 32'h0);
        samp();
        poll(`ST_DS_READY);
        expv = avg4();
        samp();
        rd(`REG_DS_RESULT);
        check(rdv, expv);
        repeat (2) samp();
        rd(`REG_STATUS);
        check({30'h0, rdv[`ST_DS_BUSY], rdv[`ST_DS_READY]}, 32'h0);
        check(n_dec, 32'h1);
        run_ds(DS_MULTI, 5'h10, 1'b1, 1'b0);
        run_ds(DS_TURBO, 5'h10, 1'b1, 1'b0);
        run_ds(DS_TURBO, 5'h11, 1'b0, 1'b0);
        run_ds(DS_CONT, 5'h10, 1'b0, 1'b0);
        run_ds(DS_CONT, 5'h14, 1'b1, 1'b1);
        wr(`REG_CTRL, 32'h000000C0);
        poll(`ST_SAR_READY);
        for (i = 0; i < 7; i++)
        begin
            ana = (i == 0) ? 12'h000 : (i == 1) ? 12'hFFF : (i == 2) ? 12'h7FF
                  : sar_word_type'($random(seed));
            if (i[0])
                pulse(1'b1);
            else
                wr(`REG_CMD, 32'h00000004);
            // a late trigger while converting must be dropped
            repeat (6) @(posedge clk);
            pulse(1'b1);
            poll(`ST_SAR_DONE);
            rd(`REG_SAR_RESULT);
            check(rdv, {20'h00000, ana});
        end
        repeat (40) @(posedge clk);
        rd(`REG_STATUS);
        check({30'h0, rdv[`ST_SAR_BUSY], rdv[`ST_SAR_DONE]}, 32'h0);
        wr(`REG_CTRL, 32'h00000040);
        poll(`ST_SAR_DONE);
        rd(`REG_SAR_RESULT);
        check(rdv, {20'h00000, ana});
        repeat (3) @(posedge clk);
        for (i = 0; i < 80 && dma_sar_req !== 1'b1; i++)
            @(posedge clk);
        check({31'h0, dma_sar_req}, 32'h1);
        wr(`REG_CTRL, 32'h000000C0);
        repeat (40) @(posedge clk);
        wr(`REG_CMD, 32'h00000008);
        rd(`REG_STATUS);
        check({31'h0, rdv[`ST_SAR_READY]}, 32'h0);
        poll(`ST_SAR_READY);
        close_out();
    end
endmodule : adc_conversion_sequencer_tb_top

/* testbench/adc_seq_checker.sv */
`timescale 1ns/1ns
module adc_seq_checker
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ds_convert_request,
    input wire logic ds_start_bit,
    input wire logic ds_stop,
    input wire logic ds_read,
    input wire logic ds_result_ready,
    input wire logic ds_busy,
    input wire logic sar_trigger,
    input wire logic sar_start_bit,
    input wire logic sar_wake,
    input wire logic sar_read,
    input wire logic sar_done_flag,
    input wire logic sar_busy,
    input wire logic sar_ready
);
    logic [7:0] wait_q;

    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    // counts the power-up wait; a wake pulse restarts it
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            wait_q <= 8'h00;
        else if (sar_wake)
            wait_q <= 8'h00;
        else if (!sar_ready && wait_q != 8'hFF)
            wait_q <= wait_q + 8'h01;
    end

    a_ds_ready_hold: assert property (ds_result_ready && !ds_read |=> ds_result_ready)
        else $error("ds ready dropped without a read");
    a_sar_done_hold: assert property (sar_done_flag && !sar_read |=> sar_done_flag)
        else $error("sar done dropped without a read");
    a_ds_start_taken: assert property ((ds_start_bit || ds_convert_request)
        && !ds_busy && !ds_stop |=> ds_busy) else $error("ds start not taken");
    a_ds_busy_exit: assert property ($fell(ds_busy) |-> $past(ds_read) || $past(ds_stop)
        || $past(ds_read, 2) || $past(ds_stop, 2)) else $error("ds left run by itself");
    a_sar_start_taken: assert property ((sar_start_bit || sar_trigger) && sar_ready
        && !sar_busy && !sar_wake |=> sar_busy) else $error("sar start not taken");
    a_sar_conv_len: assert property ($rose(sar_busy) |-> sar_busy[*8] ##[14:20] !sar_busy)
        else $error("sar conversion length wrong");
    a_sar_done_set: assert property ($fell(sar_busy) && !$past(sar_wake)
        |-> ##[0:2] sar_done_flag) else $error("sar done not raised");
    a_sar_no_early: assert property (!sar_ready |-> !sar_busy)
        else $error("sar converting before ready");
    a_sar_wait_len: assert property ($rose(sar_ready) |-> wait_q >= 8'h61 && wait_q <= 8'h67)
        else $error("sar power-up wait wrong length");
endmodule : adc_seq_checker
